//--- verilog/tsb_top.sv
// Purpose: Transmit slip buffer of one E1 channel with sticky slip event flags
// Assumes: System and line timeslot strobes are enables on the one clock
// Notes: Registers over AXI4-Lite; status flags clear when read
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`include "tsb_params.svh"

// What this block does
// [RULE1] A write into the full buffer deletes one whole frame and sets the full flag at bit 7.
// [RULE2] A read from the emptied buffer repeats one whole frame and sets the empty flag at bit 6.
// [RULE3] Either slip, deletion or repetition, sets the slip flag at bit 5.
// [RULE4] Each flag stays set until software reads the status register, and that read clears it.
// [RULE5] A flag reads 1 if its event happened since the last read, else 0, and all start at 0.
// [RULE6] Software that sees the slip flag reads bit 6 or bit 7 to learn the slip direction.
// [RULE7] The buffer is written on the system side and read on the line side and holds two frames.
module tsb_top (
	// Clock and reset
	input wire logic I_CLOCK,
	input wire logic I_SYS_RST,
	// AXI4-Lite write
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire tsb_pkg::tsb_addr_t I_AWADDR,
	input wire logic I_WVALID,
	output logic O_WREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	output logic O_BVALID,
	input wire logic I_BREADY,
	output logic [1:0] O_BRESP,
	// AXI4-Lite read
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	input wire tsb_pkg::tsb_addr_t I_ARADDR,
	output logic O_RVALID,
	input wire logic I_RREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	// System-side transmit data
	input wire tsb_pkg::tsb_byte_t I_TX_DATA,
	input wire logic I_TX_VALID,
	output logic O_TX_READY,
	input wire logic I_SYS_STROBE,
	// Line-side transmit data
	input wire logic I_LINE_STROBE,
	output tsb_pkg::tsb_byte_t O_LINE_DATA,
	output logic O_LINE_VALID
);
	import tsb_pkg::*;

	tsb_stream_if #(.W(`TSB_DATA_W)) in_if ();
	tsb_stream_if #(.W(`TSB_DATA_W)) buf_if ();

	tsb_byte_t mem_ff [`TSB_BUF_DEPTH];
	tsb_ptr_t wr_ptr_ff;
	tsb_ptr_t rd_ptr_ff;
	tsb_ptr_t rd_addr;
	tsb_cnt_t cnt_ff;
	tsb_cnt_t nxt_cnt;
	logic enable_ff;
	logic wr_do;
	logic rd_do;
	logic ovf;
	logic unf;
	logic [7:0] status_ff;
	logic [7:0] nxt_status;
	logic status_clr;
	logic aw_got_ff;
	logic w_got_ff;
	tsb_addr_t aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic awready_ff;
	logic wready_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic arready_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	tsb_byte_t line_data_ff;
	logic line_valid_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Input FIFO: holds up to four bytes while the system side does not take a timeslot; stalls the source only when full

	assign in_if.valid = I_TX_VALID;
	assign in_if.data = I_TX_DATA;
	assign O_TX_READY = in_if.ready;
	assign buf_if.ready = I_SYS_STROBE && enable_ff;

	tsb_fifo #(.W(`TSB_DATA_W), .DEPTH(`TSB_IN_FIFO_DEPTH)) u_in_fifo (
		.i_clk(I_CLOCK),
		.i_rst(I_SYS_RST),
		.s_in(in_if.snk),
		.m_out(buf_if.src)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Elastic buffer of two frames

	assign wr_do = buf_if.valid && buf_if.ready; // [RULE7]
	assign rd_do = I_LINE_STROBE && enable_ff; // [RULE7]
	// A read in the same cycle makes room, so that write is no overflow
	assign ovf = wr_do && !rd_do && (cnt_ff == `TSB_CNT_W'(`TSB_BUF_DEPTH)); // [RULE1]
	// Data written this cycle is not yet readable, so an empty read always repeats
	assign unf = rd_do && (cnt_ff == '0); // [RULE2]
	assign rd_addr = unf ? rd_ptr_ff - `TSB_PTR_W'(`TSB_FRAME_LEN) : rd_ptr_ff; // [RULE2]

	always_comb begin
		nxt_cnt = cnt_ff + `TSB_CNT_W'(wr_do) - `TSB_CNT_W'(rd_do);
		if (unf) begin
			nxt_cnt = nxt_cnt + `TSB_CNT_W'(`TSB_FRAME_LEN); // [RULE2]
		end
		if (ovf) begin
			nxt_cnt = nxt_cnt - `TSB_CNT_W'(`TSB_FRAME_LEN); // [RULE1]
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (wr_do) begin
			mem_ff[wr_ptr_ff] <= buf_if.data;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST || !enable_ff) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff <= '0;
		end else begin
			wr_ptr_ff <= wr_ptr_ff + `TSB_PTR_W'(wr_do);
			if (ovf) begin
				// Oldest frame dropped; its first slot takes the new byte
				rd_ptr_ff <= rd_ptr_ff + `TSB_PTR_W'(`TSB_FRAME_LEN); // [RULE1]
			end else if (rd_do) begin
				rd_ptr_ff <= rd_addr + `TSB_PTR_W'(1); // [RULE2]
			end
			cnt_ff <= nxt_cnt;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			line_data_ff <= '0;
			line_valid_ff <= 1'b0;
		end else begin
			line_valid_ff <= rd_do;
			if (rd_do) begin
				line_data_ff <= mem_ff[rd_addr];
			end
		end
	end

	assign O_LINE_DATA = line_data_ff;
	assign O_LINE_VALID = line_valid_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Sticky event flags: a new event wins over the clearing read

	assign status_clr = I_ARVALID && !arready_ff && !rvalid_ff && (I_ARADDR == `TSB_OFS_STATUS);

	always_comb begin
		nxt_status = status_clr ? 8'h00 : status_ff; // [RULE4]
		nxt_status[`TSB_BIT_FULL] = nxt_status[`TSB_BIT_FULL] | ovf; // [RULE1]
		nxt_status[`TSB_BIT_EMPTY] = nxt_status[`TSB_BIT_EMPTY] | unf; // [RULE2]
		nxt_status[`TSB_BIT_SLIP] = nxt_status[`TSB_BIT_SLIP] | ovf | unf; // [RULE3]
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			status_ff <= `TSB_STATUS_RESET; // [RULE5]
		end else begin
			status_ff <= nxt_status; // [RULE5]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write: address and data taken in either order

	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			aw_addr_ff <= '0;
			w_data_ff <= '0;
			w_strb_ff <= '0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `TSB_RESP_OKAY;
			enable_ff <= `TSB_CTRL_RESET;
		end else begin
			awready_ff <= I_AWVALID && !aw_got_ff && !awready_ff && !bvalid_ff;
			wready_ff <= I_WVALID && !w_got_ff && !wready_ff && !bvalid_ff;
			if (awready_ff) begin
				aw_got_ff <= 1'b1;
				aw_addr_ff <= I_AWADDR;
			end
			if (wready_ff) begin
				w_got_ff <= 1'b1;
				w_data_ff <= I_WDATA;
				w_strb_ff <= I_WSTRB;
			end
			if (aw_got_ff && w_got_ff && !bvalid_ff) begin
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= `TSB_RESP_OKAY;
				case (aw_addr_ff)
					`TSB_OFS_STATUS, `TSB_OFS_LEVEL: begin
						// Read-only words; the write is accepted and has no effect
					end
					`TSB_OFS_CTRL: begin
						if (w_strb_ff[0]) begin
							enable_ff <= w_data_ff[`TSB_CTRL_ENABLE];
						end
					end
					default: begin
						bresp_ff <= `TSB_RESP_SLVERR;
					end
				endcase
			end else if (bvalid_ff && I_BREADY) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read: the status word is returned as it stood before its clear

	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= '0;
			rresp_ff <= `TSB_RESP_OKAY;
		end else begin
			arready_ff <= 1'b0;
			if (I_ARVALID && !arready_ff && !rvalid_ff) begin
				arready_ff <= 1'b1;
				rvalid_ff <= 1'b1;
				rresp_ff <= `TSB_RESP_OKAY;
				rdata_ff <= '0;
				case (I_ARADDR)
					`TSB_OFS_STATUS: rdata_ff[7:0] <= status_ff; // [RULE4] [RULE6]
					`TSB_OFS_LEVEL: rdata_ff[`TSB_CNT_W-1:0] <= cnt_ff;
					`TSB_OFS_CTRL: rdata_ff[`TSB_CTRL_ENABLE] <= enable_ff;
					default: rresp_ff <= `TSB_RESP_SLVERR;
				endcase
			end else if (rvalid_ff && I_RREADY) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	assign O_AWREADY = awready_ff;
	assign O_WREADY = wready_ff;
	assign O_BVALID = bvalid_ff;
	assign O_BRESP = bresp_ff;
	assign O_ARREADY = arready_ff;
	assign O_RVALID = rvalid_ff;
	assign O_RDATA = rdata_ff;
	assign O_RRESP = rresp_ff;
endmodule

//--- verilog/tsb_params.svh
// Purpose: Offsets, field positions, reset values and sizes of the transmit slip buffer
// Assumes: 32-bit register bus, byte-wide E1 timeslots
// Notes: Definitions only
`ifndef TSB_PARAMS_SVH
`define TSB_PARAMS_SVH

`define TSB_ADDR_W 4
`define TSB_OFS_STATUS 4'h0
`define TSB_OFS_LEVEL 4'h4
`define TSB_OFS_CTRL 4'h8

`define TSB_BIT_FULL 7
`define TSB_BIT_EMPTY 6
`define TSB_BIT_SLIP 5
`define TSB_CTRL_ENABLE 0

`define TSB_STATUS_RESET 8'h00
`define TSB_CTRL_RESET 1'b1

`define TSB_DATA_W 8
`define TSB_FRAME_LEN 32
`define TSB_BUF_DEPTH 64
`define TSB_PTR_W 6
`define TSB_CNT_W 7
`define TSB_IN_FIFO_DEPTH 4

`define TSB_RESP_OKAY 2'h0
`define TSB_RESP_SLVERR 2'h2

`endif

//--- verilog/tsb_pkg.sv
// Purpose: Shared types of the transmit slip buffer
// Assumes: Constants come from tsb_params.svh
// Notes: Types only
`include "tsb_params.svh"
package tsb_pkg;
	typedef logic [`TSB_DATA_W-1:0] tsb_byte_t;
	typedef logic [`TSB_PTR_W-1:0] tsb_ptr_t;
	typedef logic [`TSB_CNT_W-1:0] tsb_cnt_t;
	typedef logic [`TSB_ADDR_W-1:0] tsb_addr_t;
endpackage

//--- verilog/tsb_stream_if.sv
// Purpose: Valid/ready byte stream between the slip buffer modules
// Assumes: One clock
// Notes: An item moves when valid and ready are both high
`timescale 1ns/1ns
interface tsb_stream_if #(parameter int W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

//--- verilog/tsb_fifo.sv
// Purpose: Small parameterised FIFO with valid and ready on both sides
// Assumes: Synchronous active-high reset
// Notes: Ready toward the source comes from a flop
`timescale 1ns/1ns
module tsb_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Streams
	tsb_stream_if.snk s_in,
	tsb_stream_if.src m_out
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0] cnt_ff;
	logic [AW:0] nxt_cnt;
	logic ready_ff;
	logic push;
	logic pop;

	assign push = s_in.valid && ready_ff;
	assign pop = m_out.valid && m_out.ready;
	assign s_in.ready = ready_ff;
	assign m_out.valid = (cnt_ff != '0);
	assign m_out.data = mem_ff[rd_ptr_ff];
	assign nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= s_in.data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff <= '0;
			ready_ff <= 1'b0;
		end else begin
			wr_ptr_ff <= wr_ptr_ff + AW'(push);
			rd_ptr_ff <= rd_ptr_ff + AW'(pop);
			cnt_ff <= nxt_cnt;
			// Honest full: ready drops in the cycle the last slot fills
			ready_ff <= (nxt_cnt < (AW+1)'(DEPTH));
		end
	end
endmodule

//--- test/tsb_chk.sv
// Purpose: Port assertions of tsb_top
// Assumes: One clock, sync active-high reset
// Notes: Bound from tb_top
`timescale 1ns/1ns
`include "tsb_params.svh"
module tsb_chk (
	// Watched inputs
	input wire logic I_CLOCK, I_SYS_RST, I_AWVALID, I_BREADY, I_ARVALID, I_RREADY, I_LINE_STROBE,
	input wire tsb_pkg::tsb_addr_t I_ARADDR,
	// Watched outputs
	input wire logic O_AWREADY, O_BVALID, O_ARREADY, O_RVALID, O_LINE_VALID,
	input wire logic [31:0] O_RDATA
);
	import tsb_pkg::*;
	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (I_SYS_RST);
	////////////////////////////////////////
	property p_line; I_LINE_STROBE |=> O_LINE_VALID; endproperty
	a_line: assert property (p_line) else $error("line byte missing");
	property p_noline; !I_LINE_STROBE |=> !O_LINE_VALID; endproperty
	a_noline: assert property (p_noline) else $error("stray line byte");
	// Slip can never be read without its direction, as all three clear together
	property p_slip; $rose(O_RVALID) && I_ARADDR == `TSB_OFS_STATUS
		|-> O_RDATA[5] == |O_RDATA[7:6] && {O_RDATA[31:8], O_RDATA[4:0]} == 0; endproperty
	a_slip: assert property (p_slip) else $error("slip flag disagrees");
	property p_rd; I_ARVALID && !O_ARREADY && !O_RVALID |=> O_ARREADY && O_RVALID; endproperty
	a_rd: assert property (p_rd) else $error("read answer late");
	property p_rhold; O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA); endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");
	property p_aw; O_AWREADY |=> !O_AWREADY; endproperty
	a_aw: assert property (p_aw) else $error("awready too long");
	property p_bv; I_AWVALID && O_AWREADY |-> ##[1:3] O_BVALID; endproperty
	a_bv: assert property (p_bv) else $error("write response late");
	property p_bhold; O_BVALID && !I_BREADY |=> O_BVALID; endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");
	c_slip: cover property ($rose(O_RVALID) && O_RDATA[5]);
	c_line: cover property (O_LINE_VALID);
	c_wr: cover property (O_BVALID && I_BREADY);
endmodule

//--- test/tsb_src.sv
// Purpose: System-side byte source
// Assumes: Valid held until ready
// Notes: Byte n carries n; data scrambled while idle
`timescale 1ns/1ns
module tsb_src (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Control
	input wire logic [7:0] i_limit,
	output logic o_done,
	// Stream
	input wire logic i_ready,
	output logic o_valid,
	output logic [7:0] o_data
);
	logic [7:0] sent = 8'h00;
	logic [7:0] nxt;
	logic v;
	assign nxt = sent + {7'h0, o_valid & i_ready};
	assign o_done = sent == i_limit;
	always @(posedge i_clk) begin
		sent <= i_rst ? 8'h00 : nxt;
		if (i_rst || !o_valid || i_ready) begin
			// Random gaps: a source that cannot always keep up
			v = !i_rst && nxt != i_limit && $urandom_range(3) != 0;
			o_valid <= v;
			o_data <= v ? nxt : ~nxt;
		end
	end
endmodule

//--- test/tb_top.sv
// Purpose: Self-checking bench of tsb_top
// Assumes: Enable is 1 except in the last test; system strobe in three slots of four at random
// Notes: Source sends 0,1,2.. so line bytes are predictable
`timescale 1ns/1ns
`include "tsb_params.svh"
module tb_top;
	import tsb_pkg::*;
	logic clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, lstb = 0, sstb = 0;
	tsb_addr_t awa = 4'h0, ara = 4'h0;
	logic [31:0] wd = 32'h0, rdat;
	logic [1:0] bresp, rresp, wresp;
	logic awr, wrdy, bv, arr, rv, txr, txv, lv, done;
	tsb_byte_t txd, ld;
	logic [7:0] lim = 8'h00;
	int fail_count = 0, n_checks = 0;
	tsb_top i_dut (.I_CLOCK(clk), .I_SYS_RST(rst), .I_AWVALID(awv), .O_AWREADY(awr), .I_AWADDR(awa),
		.I_WVALID(wv), .O_WREADY(wrdy), .I_WDATA(wd), .I_WSTRB(4'hf), .O_BVALID(bv), .I_BREADY(bry),
		.O_BRESP(bresp), .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara), .O_RVALID(rv), .I_RREADY(rry),
		.O_RDATA(rdat), .O_RRESP(rresp), .I_TX_DATA(txd), .I_TX_VALID(txv), .O_TX_READY(txr),
		.I_SYS_STROBE(sstb), .I_LINE_STROBE(lstb), .O_LINE_DATA(ld), .O_LINE_VALID(lv));
	tsb_src i_src (.i_clk(clk), .i_rst(rst), .i_limit(lim), .o_done(done), .i_ready(txr), .o_valid(txv),
		.o_data(txd));
	initial forever #5 clk = ~clk;
	// Gaps in the system timeslots let the input FIFO back up
	always @(posedge clk) sstb <= $urandom_range(3) != 0;
	////////////////////////////////////////
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("FAIL %s exp %h got %h", n, e, g);
		end
	endtask
	// Ready comes late at random so the holding of read responses is seen; bready is always up by the time bvalid rises
	task automatic wr(tsb_addr_t a, logic [31:0] d);
		awa <= a; wd <= d; awv <= 1; wv <= 1;
		repeat ($urandom_range(3)) begin
			@(posedge clk); if (awr) awv <= 0; if (wrdy) wv <= 0;
		end
		bry <= 1;
		do begin @(posedge clk); if (awr) awv <= 0; if (wrdy) wv <= 0; end while (!bv);
		wresp = bresp;
		bry <= 0;
		@(posedge clk);
	endtask
	task automatic rd(tsb_addr_t a, output logic [31:0] d, output logic [1:0] r);
		ara <= a; arv <= 1;
		repeat ($urandom_range(3)) begin @(posedge clk); if (arr) arv <= 0; end
		rry <= 1;
		do begin @(posedge clk); if (arr) arv <= 0; end while (!rv);
		d = rdat; r = rresp; rry <= 0;
		@(posedge clk);
	endtask
	task automatic rchk(string n, tsb_addr_t a, logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(n, e, d);
		chk("rresp", {30'h0, `TSB_RESP_OKAY}, {30'h0, r});
	endtask
	task automatic pull(int n, logic [7:0] e0);
		for (int i = 0; i < n; i++) begin
			lstb <= 1; @(posedge clk); lstb <= 0; @(posedge clk);
			chk("line byte", {23'h0, 1'b1, e0 + 8'(i)}, {23'h0, lv, ld});
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d fails %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#100000;
		fail_count++;
		wrap_up();
	end
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		void'($urandom(32'h2a96_7533));
		repeat (8) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		rchk("status", `TSB_OFS_STATUS, 32'h0);
		rchk("ctrl", `TSB_OFS_CTRL, 32'h1);
		wr(`TSB_OFS_STATUS, $urandom);
		wr(`TSB_OFS_CTRL, $urandom | 32'h1);
		chk("bresp", {30'h0, `TSB_RESP_OKAY}, {30'h0, wresp});
		wr(4'hc, $urandom);
		chk("bresp unmapped", {30'h0, `TSB_RESP_SLVERR}, {30'h0, wresp});
		rchk("status", `TSB_OFS_STATUS, 32'h0);
		rd(4'hc, d, r);
		chk("unmapped", {30'h0, `TSB_RESP_SLVERR}, {d[29:0], r});
		$display("register test done");
		lim <= 8'd65;
		// Let the new limit land before done is looked at
		@(posedge clk);
		while (!done) @(posedge clk);
		for (int k = 0; k < 40 && d !== 32'd33; k++) rd(`TSB_OFS_LEVEL, d, r);
		chk("level", 32'd33, d);
		repeat ($urandom_range(30)) @(posedge clk);
		rchk("status", `TSB_OFS_STATUS, 32'h0000_00a0);
		rchk("status", `TSB_OFS_STATUS, 32'h0);
		pull(33, 8'd32);
		rchk("status", `TSB_OFS_STATUS, 32'h0);
		$display("overflow test done");
		pull(1, 8'd33);
		rchk("level", `TSB_OFS_LEVEL, 32'd31);
		rchk("status", `TSB_OFS_STATUS, 32'h0000_0060);
		rchk("status", `TSB_OFS_STATUS, 32'h0);
		pull(31, 8'd34);
		$display("underflow test done");
		lim <= 8'd70;
		@(posedge clk);
		while (!done) @(posedge clk);
		for (int k = 0; k < 40 && d !== 32'd5; k++) rd(`TSB_OFS_LEVEL, d, r);
		chk("level", 32'd5, d);
		wr(`TSB_OFS_CTRL, 32'h0);
		rchk("flushed level", `TSB_OFS_LEVEL, 32'h0);
		rchk("ctrl", `TSB_OFS_CTRL, 32'h0);
		wr(`TSB_OFS_CTRL, 32'h1);
		rchk("ctrl", `TSB_OFS_CTRL, 32'h1);
		$display("enable test done");
		wrap_up();
	end
endmodule
bind tsb_top tsb_chk i_chk (.I_CLOCK, .I_SYS_RST, .I_AWVALID, .I_BREADY, .I_ARVALID, .I_RREADY,
	.I_LINE_STROBE, .I_ARADDR, .O_AWREADY, .O_BVALID, .O_ARREADY, .O_RVALID, .O_LINE_VALID, .O_RDATA);
